// *** pkg/dcp_pkg.sv ***
package dcp_pkg;
   // ***************************************************
   // register map (classic Wishbone, 32-bit, byte addresses)
   // ***************************************************
   localparam logic [3:0] DCP_CTRL_OFS = 4'h0;
   localparam logic [3:0] DCP_STAT_OFS = 4'h4;
   localparam logic [3:0] DCP_BEAT_OFS = 4'h8;
   // ctrl fields
   localparam int DCP_BL_LSB = 0;
   localparam int DCP_BT_BIT = 3;
   localparam logic [1:0] DCP_BL_FIX8 = 2'h0;
   localparam logic [1:0] DCP_BL_OTF = 2'h1;
   localparam logic [1:0] DCP_BL_FIX4 = 2'h2;
   localparam logic [3:0] DCP_CTRL_RST = 4'h0;
   // ***************************************************
   // commands decoded from cs_n, act_n, ras_n, cas_n, we_n
   // ***************************************************
   typedef enum logic [2:0]
   {
      DCP_CMD_DES = 3'h0,
      DCP_CMD_NOP = 3'h1,
      DCP_CMD_REF = 3'h2,
      DCP_CMD_RD = 3'h3,
      DCP_CMD_WR = 3'h4,
      DCP_CMD_ACT = 3'h5,
      DCP_CMD_PRE = 3'h6,
      DCP_CMD_OTH = 3'h7
   } dcp_cmd_t;
   typedef enum logic [4:0]
   {
      DCP_ST_IDLE = 5'h01,
      DCP_ST_ACTIVE = 5'h02,
      DCP_ST_PPD = 5'h04,
      DCP_ST_APD = 5'h08,
      DCP_ST_SREF = 5'h10
   } dcp_state_t;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int DCP_CLK_MHZ = 250;
   localparam int DCP_BURST_BEATS = 8;
   localparam int DCP_BC4_BEATS = 4;
   localparam int DCP_BC4_PULLIN = 2;
   localparam logic [3:0] DCP_WR_START = 4'h4;
   localparam logic [3:0] DCP_XS_CYC = 4'hA;
   localparam logic [3:0] DCP_XP_CYC = 4'h3;
endpackage

// *** core/dcp_core.sv ***
`timescale 1ns/1ps
// Overview of operation
// - sample CKE and command every rising edge
// - transitions use CKE at N and N-1
// - CKE low twice keeps state, ignores pins
// - closed banks give precharge power-down, else active
// - no refresh while in power-down
// - self-refresh only from idle with refresh
// - idle needs banks closed, no burst, timings met
// - termination off in self-refresh, ODT ignored
// - undefined combinations are illegal, flagged
// - burst length from MR0 A1:A0, A12 otf
// - sequential order wraps inside groups of four
// - interleaved order is start xor beat
// - column bits 2:0 choose first read beat
// - BC4 read tristates last four beat slots
// - writes ignore low column bits, A2 for BC4
// - fixed BC4 write starts two clocks earlier
// - on-the-fly BC4 write starts like BL8
module dcp_core
   import dcp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic act_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic a12_i,
   input wire logic [2:0] col_i,
   input wire logic odt_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [2:0] beat_idx_o,
   output logic beat_oe_o,
   output logic beat_wr_o,
   output logic wr_start_o,
   output logic refresh_o,
   output logic odt_en_o,
   output logic [4:0] pwr_state_o,
   output logic illegal_o
);
   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      // cke history
      logic [2:0] sync_cke;
      logic cke_prev;
      logic cke_cur;
      // power state and exit timer
      dcp_state_t st;
      logic [3:0] ctrl;
      logic [3:0] banks;
      logic [3:0] tmr;
      // burst engine
      logic rd_busy;
      logic wr_busy;
      logic [3:0] beat;
      logic [2:0] start;
      logic interleave;
      logic chop;
      logic [3:0] wdly;
      logic [2:0] beat_idx;
      logic beat_oe;
      logic beat_wr;
      logic wr_start;
      logic refresh;
      logic illegal;
      // register bus
      logic ack;
      logic [31:0] rdat;
   } dcp_st_t;
   dcp_st_t s_reg;
   dcp_st_t s_next;
   // ***************************************************
   // helpers
   // ***************************************************
   // command decode from the five command pins
   function automatic dcp_cmd_t dcp_decode(input logic cs_n, input logic act_n,
                                           input logic ras_n, input logic cas_n,
                                           input logic we_n);
      dcp_cmd_t c;
      c = DCP_CMD_OTH;
      if (cs_n)
         c = DCP_CMD_DES;
      // act low turns the other three pins into address bits
      else if (!act_n)
         c = DCP_CMD_ACT;
      else
      begin
         unique case ({ras_n, cas_n, we_n})
            3'h7: c = DCP_CMD_NOP;
            3'h1: c = DCP_CMD_REF;
            3'h2: c = DCP_CMD_PRE;
            3'h5: c = DCP_CMD_RD;
            3'h4: c = DCP_CMD_WR;
            default: c = DCP_CMD_OTH;
         endcase
      end
      return c;
   endfunction
   // sequential wraps in groups of four, interleaved is a plain xor
   function automatic logic [2:0] dcp_order(input logic [2:0] st, input logic [2:0] n,
                                            input logic il);
      logic [2:0] r;
      r = 3'h0;
      if (il)
         r = st ^ n;
      else
         r = {st[2] ^ n[2], 2'(st[1:0] + n[1:0])};
      return r;
   endfunction
   // read word for a register offset; unmapped offsets read as zero
   function automatic logic [31:0] dcp_rd_word(input logic [3:0] ofs, input dcp_st_t s);
      logic [31:0] w;
      w = 32'h0;
      unique case (ofs)
         DCP_CTRL_OFS: w = {28'h0, s.ctrl};
         DCP_STAT_OFS: w = {20'h0, s.banks, s.rd_busy, s.wr_busy, s.cke_cur, s.st};
         DCP_BEAT_OFS: w = {24'h0, s.beat, 1'b0, s.beat_idx};
         default: w = 32'h0;
      endcase
      return w;
   endfunction
   // ***************************************************
   // next state
   // ***************************************************
   dcp_cmd_t cmd;
   logic cmd_ok;
   logic wb_hit;
   always_comb
   begin
      s_next = s_reg;
      cmd = dcp_decode(cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i);
      cmd_ok = 1'b1;
      // a request is taken once; the ack cycle itself is no new hit
      wb_hit = wb_cyc_i && wb_stb_i && !s_reg.ack;
      s_next.refresh = 1'b0;
      s_next.wr_start = 1'b0;
      s_next.illegal = 1'b0;
      s_next.ack = wb_hit;
      // ***************************************************
      // cke synchroniser
      // ***************************************************
      // three flops; a new level counts once the last two agree
      s_next.sync_cke = {s_reg.sync_cke[1:0], cke_i};
      if (s_reg.sync_cke[2] == s_reg.sync_cke[1])
      begin
         s_next.cke_cur = s_reg.sync_cke[2];
      end
      // previous edge level, paired with the current one below
      s_next.cke_prev = s_reg.cke_cur;
      // ***************************************************
      // exit lockout timer
      // ***************************************************
      // commands are ignored until the exit recovery runs out
      if (s_reg.tmr != 4'h0)
      begin
         s_next.tmr = s_reg.tmr - 4'h1;
      end
      // ***************************************************
      // burst engine
      // ***************************************************
      // beat counter runs a full eight slots even for a chop
      if (s_reg.rd_busy || s_reg.wr_busy)
      begin
         s_next.beat = s_reg.beat + 4'h1;
         s_next.beat_idx = dcp_order(s_reg.start, s_reg.beat[2:0] + 3'h1, s_reg.interleave);
         // chop: outputs released for the last four slots
         if (s_reg.chop && s_reg.beat[2:0] == 3'(DCP_BC4_BEATS - 1))
            s_next.beat_oe = 1'b0;
         if (s_reg.beat == 4'(DCP_BURST_BEATS - 1))
         begin
            s_next.rd_busy = 1'b0;
            s_next.wr_busy = 1'b0;
            s_next.beat_oe = 1'b0;
            s_next.beat_wr = 1'b0;
         end
      end
      // ***************************************************
      // internal write start
      // ***************************************************
      // delay counter ends in a one cycle start pulse
      if (s_reg.wdly != 4'h0)
      begin
         s_next.wdly = s_reg.wdly - 4'h1;
         if (s_reg.wdly == 4'h1)
            s_next.wr_start = 1'b1;
      end
      // ***************************************************
      // power state machine
      // ***************************************************
      unique case (s_reg.st)
         DCP_ST_PPD, DCP_ST_APD, DCP_ST_SREF:
         begin
            // low at both edges: hold, pins are don't care
            if (!s_reg.cke_prev && !s_reg.cke_cur)
               s_next.st = s_reg.st;
            // rising cke: leave power-down or self-refresh
            else if (!s_reg.cke_prev && s_reg.cke_cur)
            begin
               cmd_ok = (cmd == DCP_CMD_DES) || (s_reg.st == DCP_ST_SREF && cmd == DCP_CMD_NOP);
               s_next.st = (s_reg.st == DCP_ST_APD) ? DCP_ST_ACTIVE : DCP_ST_IDLE;
               s_next.tmr = (s_reg.st == DCP_ST_SREF) ? DCP_XS_CYC : DCP_XP_CYC;
            end
            else
               cmd_ok = 1'b0;
         end
         default:
         begin
            // falling cke: enter power-down or self-refresh
            if (s_reg.cke_prev && !s_reg.cke_cur)
            begin
               if (cmd == DCP_CMD_REF && s_reg.banks == 4'h0 && !s_reg.rd_busy
                   && !s_reg.wr_busy && s_reg.tmr == 4'h0)
                  s_next.st = DCP_ST_SREF;
               else if (cmd == DCP_CMD_DES)
                  s_next.st = (s_reg.banks == 4'h0) ? DCP_ST_PPD : DCP_ST_APD;
               else
                  cmd_ok = 1'b0;
            end
            // cke high and no exit lockout: normal command decode
            else if (s_reg.cke_cur && s_reg.tmr == 4'h0)
            begin
               unique case (cmd)
                  // one open-bank flag stands for all banks
                  DCP_CMD_ACT: s_next.banks[1'b0] = 1'b1;
                  DCP_CMD_PRE: s_next.banks = 4'h0;
                  // refresh is only valid with all banks closed
                  DCP_CMD_REF:
                  begin
                     s_next.refresh = 1'b1;
                     cmd_ok = (s_reg.banks == 4'h0);
                  end
                  // reads and writes restart the burst engine
                  DCP_CMD_RD, DCP_CMD_WR:
                  begin
                     s_next.beat = 4'h0;
                     s_next.interleave = s_reg.ctrl[DCP_BT_BIT];
                     s_next.chop = (s_reg.ctrl[1:0] == DCP_BL_FIX4) ||
                                   (s_reg.ctrl[1:0] == DCP_BL_OTF && !a12_i);
                     if (cmd == DCP_CMD_RD)
                     begin
                        s_next.rd_busy = 1'b1;
                        s_next.wr_busy = 1'b0;
                        s_next.start = col_i;
                        s_next.beat_idx = dcp_order(col_i, 3'h0, s_reg.ctrl[DCP_BT_BIT]);
                        s_next.beat_oe = 1'b1;
                        s_next.beat_wr = 1'b0;
                     end
                     else
                     begin
                        s_next.wr_busy = 1'b1;
                        s_next.rd_busy = 1'b0;
                        s_next.interleave = 1'b0;
                        // write order starts at 0 or 4, column bits 1:0 ignored
                        s_next.start = (s_next.chop) ? {col_i[2], 2'h0} : 3'h0;
                        s_next.beat_idx = s_next.start;
                        s_next.beat_oe = 1'b0;
                        s_next.beat_wr = 1'b1;
                        if (s_reg.ctrl[1:0] == DCP_BL_FIX4)
                        begin
                           s_next.wdly = DCP_WR_START - 4'(DCP_BC4_PULLIN);
                        end
                        else
                        begin
                           s_next.wdly = DCP_WR_START;
                        end
                     end
                  end
                  default: ;
               endcase
               s_next.st = (s_next.banks != 4'h0) ? DCP_ST_ACTIVE : DCP_ST_IDLE;
            end
            // cke low at both edges lies outside the defined transitions
            else if (!s_reg.cke_cur)
               cmd_ok = 1'b0;
         end
      endcase
      s_next.illegal = !cmd_ok;
      // ***************************************************
      // register bus
      // ***************************************************
      // a write lands at the edge that sees ack high
      if (wb_cyc_i && wb_stb_i && s_reg.ack && wb_we_i && wb_adr_i[3:0] == DCP_CTRL_OFS
          && wb_sel_i[0])
      begin
         s_next.ctrl = wb_dat_i[3:0];
      end
      s_next.rdat = dcp_rd_word(wb_adr_i[3:0], s_reg);
   end
   // ***************************************************
   // registers
   // ***************************************************
   // one synchronous reset for the whole state word
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_reg <= '0;
         s_reg.st <= DCP_ST_IDLE;
         s_reg.ctrl <= DCP_CTRL_RST;
      end
      else
         s_reg <= s_next;
   end
   // ***************************************************
   // outputs
   // ***************************************************
   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.rdat;
   assign beat_idx_o = s_reg.beat_idx;
   // low marks the released (high impedance) beat slots
   assign beat_oe_o = s_reg.beat_oe;
   assign beat_wr_o = s_reg.beat_wr;
   assign wr_start_o = s_reg.wr_start;
   assign refresh_o = s_reg.refresh;
   // termination follows the pin except in self-refresh
   assign odt_en_o = odt_i && (s_reg.st != DCP_ST_SREF);
   assign pwr_state_o = s_reg.st;
   assign illegal_o = s_reg.illegal;
endmodule // dcp_core

// *** verif/dcp_core_sva.sv ***
`timescale 1ns/1ps
module dcp_core_sva
   import dcp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic act_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [2:0] col_i,
   input wire logic odt_i,
   input wire logic [2:0] beat_idx_o,
   input wire logic beat_oe_o,
   input wire logic beat_wr_o,
   input wire logic wr_start_o,
   input wire logic refresh_o,
   input wire logic odt_en_o,
   input wire logic [4:0] pwr_state_o
);
   // ***************************************
   // power state and burst checks
   // ***************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire logic rd_c = !cs_n_i && act_n_i && ras_n_i && !cas_n_i && we_n_i;
   wire logic wr_c = !cs_n_i && act_n_i && ras_n_i && !cas_n_i && !we_n_i;
   wire logic go = pwr_state_o == DCP_ST_ACTIVE && !beat_oe_o && !beat_wr_o;
   property p_odt;
      odt_en_o == (odt_i && pwr_state_o != DCP_ST_SREF);
   endproperty
   a_odt: assert property (p_odt)
      else $error("odt enable wrong");
   property p_rd;
      rd_c && go |=> beat_oe_o && beat_idx_o == $past(col_i);
   endproperty
   a_rd: assert property (p_rd)
      else $error("read first beat wrong");
   property p_bc4;
      $rose(beat_oe_o) |-> beat_oe_o [*4];
   endproperty
   a_bc4: assert property (p_bc4)
      else $error("read burst shorter than four");
   property p_sre;
      pwr_state_o == DCP_ST_SREF && $past(pwr_state_o) != DCP_ST_SREF
         |-> $past(pwr_state_o) == DCP_ST_IDLE;
   endproperty
   a_sre: assert property (p_sre)
      else $error("self refresh entered from non idle");
   property p_apd;
      pwr_state_o == DCP_ST_APD && $past(pwr_state_o) != DCP_ST_APD
         |-> $past(pwr_state_o) == DCP_ST_ACTIVE;
   endproperty
   a_apd: assert property (p_apd)
      else $error("active power down without open bank");
   property p_pdr;
      pwr_state_o inside {DCP_ST_PPD, DCP_ST_APD} |-> !refresh_o;
   endproperty
   a_pdr: assert property (p_pdr)
      else $error("refresh in power down");
   property p_wr;
      wr_c && go |-> ##[1:16] wr_start_o;
   endproperty
   a_wr: assert property (p_wr)
      else $error("internal write never started");
   property p_hot;
      $onehot(pwr_state_o);
   endproperty
   a_hot: assert property (p_hot)
      else $error("power state not one hot");
   c_sref: cover property (pwr_state_o == DCP_ST_SREF);
   c_apd: cover property (pwr_state_o == DCP_ST_APD);
   c_chop: cover property ($fell(beat_oe_o));
endmodule // dcp_core_sva
bind dcp_core dcp_core_sva u_sva (.clk_i, .rst_i, .cs_n_i, .act_n_i, .ras_n_i, .cas_n_i,
   .we_n_i, .col_i, .odt_i, .beat_idx_o, .beat_oe_o, .beat_wr_o, .wr_start_o, .refresh_o,
   .odt_en_o, .pwr_state_o);

// *** verif/dcp_ctl_mdl.sv ***
`timescale 1ns/1ps
module dcp_ctl_mdl
   import dcp_pkg::*;
(
   input wire logic clk_i,
   input wire dcp_cmd_t cmd_i,
   output logic [4:0] pin_o
);
   // ***************************************
   // command pins {cs_n, act_n, ras_n, cas_n, we_n}
   // ***************************************
   logic tgl = 1'b0;
   always_ff @(posedge clk_i)
   begin
      tgl <= !tgl;
   end
   always_comb
   begin
      case (cmd_i)
         DCP_CMD_NOP: pin_o = 5'h0F;
         DCP_CMD_REF: pin_o = 5'h09;
         DCP_CMD_RD: pin_o = 5'h0D;
         DCP_CMD_WR: pin_o = 5'h0C;
         DCP_CMD_ACT: pin_o = 5'h00;
         DCP_CMD_PRE: pin_o = 5'h0A;
         // deselect: unselected pins wander every cycle
         default: pin_o = {1'b1, {4{tgl}}};
      endcase
   end
endmodule // dcp_ctl_mdl

// *** verif/dcp_core_tb_top.sv ***
`timescale 1ns/1ps
module dcp_core_tb_top
   import dcp_pkg::*;
;
   logic clk_i = 1'b0, rst_i = 1'b1, cke = 1'b1, a12 = 1'b1, odt = 1'b0;
   logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, oe, bwr, wst, rfr, oen;
   logic [2:0] col = 3'h0, idx;
   logic [3:0] adr = 4'h0;
   logic [4:0] pins, st;
   logic [31:0] wdat = 32'h0, rdat, q;
   dcp_cmd_t cmd = DCP_CMD_DES;
   int error_cnt = 0, tests_run = 0, ta, tb, tc, n;
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) odt <= 1'($urandom);
   dcp_ctl_mdl ctl (.clk_i, .cmd_i(cmd), .pin_o(pins));
   dcp_core uut (.clk_i, .rst_i, .cke_i(cke), .cs_n_i(pins[4]), .act_n_i(pins[3]),
      .ras_n_i(pins[2]), .cas_n_i(pins[1]), .we_n_i(pins[0]), .a12_i(a12), .col_i(col),
      .odt_i(odt), .wb_adr_i(32'(adr)), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .beat_idx_o(idx),
      .beat_oe_o(oe), .beat_wr_o(bwr), .wr_start_o(wst), .refresh_o(rfr), .odt_en_o(oen),
      .pwr_state_o(st), .illegal_o());
   // ***************************************
   // reference model and helpers
   // ***************************************
   function automatic logic [2:0] ord(logic [2:0] c, logic [2:0] k, logic il);
      return il ? (c ^ k) : {c[2] ^ k[2], 2'(c[1:0] + k[1:0])};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wrap_up();
      $display("TB: errors=%0d tests=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      chk(32'(ack), 32'h1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic step(input dcp_cmd_t c);
      cmd <= c;
      @(posedge clk_i);
   endtask
   task automatic wait_st(input logic [4:0] s);
      n = 0;
      while (st !== s && n < 40)
      begin
         step(DCP_CMD_DES);
         n++;
      end
      chk(32'(st), 32'(s));
   endtask
   task automatic rd(input logic [2:0] c, input logic il, input logic b8);
      logic e;
      col <= c;
      step(DCP_CMD_RD);
      step(DCP_CMD_DES);
      for (int k = 0; k < 8; k++)
      begin
         e = b8 || k < 4;
         chk({oe, e ? idx : 3'h0}, {e, e ? ord(c, 3'(k), il) : 3'h0});
         @(posedge clk_i);
      end
   endtask
   task automatic wr(output int d, output int c);
      col <= 3'($urandom);
      step(DCP_CMD_WR);
      d = 0;
      c = 0;
      for (int k = 1; k < 24; k++)
      begin
         step(DCP_CMD_DES);
         c += int'(bwr === 1'b1);
         if (wst === 1'b1 && d == 0)
            d = k;
      end
   endtask
   initial
   begin
      #20000;
      error_cnt++;
      wrap_up();
   end
   initial
   begin
      void'($urandom(22910));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      wb(1'b0, DCP_CTRL_OFS, 32'h0);
      chk(q, 32'(DCP_CTRL_RST));
      wb(1'b0, 4'hC, 32'h0);
      chk(q, 32'h0);
      wb(1'b1, DCP_CTRL_OFS, 32'h0000000A);
      wb(1'b0, DCP_CTRL_OFS, 32'h0);
      chk(q & 32'hF, 32'h0000000A);
      step(DCP_CMD_ACT);
      wait_st(DCP_ST_ACTIVE);
      for (int i = 0; i < 16; i++)
      begin
         wb(1'b1, DCP_CTRL_OFS, 32'(i / 8) << DCP_BT_BIT);
         rd(3'(i), 1'(i / 8), 1'b1);
      end
      wb(1'b1, DCP_CTRL_OFS, 32'(DCP_BL_FIX4));
      rd(3'($urandom), 1'b0, 1'b0);
      wb(1'b1, DCP_CTRL_OFS, 32'h8 | 32'(DCP_BL_OTF));
      a12 <= 1'b0;
      rd(3'($urandom), 1'b1, 1'b0);
      a12 <= 1'b1;
      rd(3'($urandom), 1'b1, 1'b1);
      wb(1'b1, DCP_CTRL_OFS, 32'(DCP_BL_FIX8));
      wr(ta, n);
      chk(32'(n), 32'(DCP_BURST_BEATS));
      chk(32'(ta > DCP_BC4_PULLIN), 32'h1);
      wb(1'b1, DCP_CTRL_OFS, 32'(DCP_BL_OTF));
      a12 <= 1'b0;
      wr(tb, n);
      chk(32'(tb), 32'(ta));
      wb(1'b1, DCP_CTRL_OFS, 32'(DCP_BL_FIX4));
      wr(tc, n);
      chk(32'(tc), 32'(ta - DCP_BC4_PULLIN));
      step(DCP_CMD_PRE);
      wait_st(DCP_ST_IDLE);
      // power down from idle, refresh requests must be ignored
      cke <= 1'b0;
      wait_st(DCP_ST_PPD);
      repeat (4) step(DCP_CMD_REF);
      wb(1'b0, DCP_STAT_OFS, 32'h0);
      chk(q & 32'h3F, 32'(DCP_ST_PPD));
      cke <= 1'b1;
      wait_st(DCP_ST_IDLE);
      repeat (DCP_XP_CYC) step(DCP_CMD_DES);
      step(DCP_CMD_ACT);
      wait_st(DCP_ST_ACTIVE);
      cke <= 1'b0;
      wait_st(DCP_ST_APD);
      cke <= 1'b1;
      wait_st(DCP_ST_ACTIVE);
      repeat (DCP_XP_CYC) step(DCP_CMD_DES);
      step(DCP_CMD_PRE);
      wait_st(DCP_ST_IDLE);
      cke <= 1'b0;
      step(DCP_CMD_DES);
      repeat (4) step(DCP_CMD_REF);
      wait_st(DCP_ST_SREF);
      @(posedge clk_i);
      chk(32'(oen), 32'h0);
      cke <= 1'b1;
      wait_st(DCP_ST_IDLE);
      wrap_up();
   end
endmodule // dcp_core_tb_top
